//--- core/csr_core_special_regs.v
// Purpose : Stack pointer, primary working register, second operand register and flag word
// Assumes : Datapath and software share one clock; inputs synchronous to I_CLOCK
// Notes   : Software writes win over datapath updates in the same cycle, except the parity flag, which always follows the primary register
`include "csr_core_regs.vh"

module csr_core_special_regs (
   input  wire       I_CLOCK,
   input  wire       I_SYS_RST,
   // Special-function access from software
   input  wire [7:0] I_SFR_ADDR,
   input  wire       I_SFR_WR,
   input  wire [7:0] I_SFR_WDATA,
   input  wire       I_SFR_RD,
   input  wire [7:0] I_BIT_ADDR,
   input  wire       I_BIT_WR,
   input  wire       I_BIT_WVAL,
   // Datapath stack operations
   input  wire       I_PUSH,
   input  wire       I_POP,
   // Datapath results
   input  wire       I_PRIMARY_LD,
   input  wire [7:0] I_PRIMARY_VAL,
   input  wire       I_SECOND_LD,
   input  wire [7:0] I_SECOND_VAL,
   input  wire       I_ADD_OP,
   input  wire       I_SUB_OP,
   input  wire       I_CARRY_IN,
   input  wire [7:0] I_OPND,
   input  wire       I_MUL_OP,
   input  wire       I_DIV_OP,
   input  wire       I_CARRY_LD,
   input  wire       I_CARRY_VAL,
   // Register views
   output reg  [7:0] O_SFR_RDATA,
   output reg        O_SFR_HIT,
   output reg  [7:0] O_STACK_TOP_POINTER,
   output reg  [7:0] O_PUSH_ADDR,
   output reg  [7:0] O_PRIMARY_WORKING_REG,
   output reg  [7:0] O_SECOND_OPERAND_REG,
   output reg  [7:0] O_CPU_FLAGS_WORD,
   output reg  [7:0] O_BANK_BASE
);

   // ==================================================
   // Registers and write merging
   reg  [7:0] sp_r;
   reg  [7:0] acc_r;
   reg  [7:0] sec_r;
   reg  [7:0] flg_r;
   wire [7:0] sp_sw;
   wire [7:0] acc_sw;
   wire [7:0] sec_sw;
   wire [7:0] flg_sw;
   wire       sp_hit;
   wire       acc_hit;
   wire       acc_bhit;
   wire       sec_hit;
   wire       sec_bhit;
   wire       flg_hit;
   wire       flg_bhit;

   // The stack pointer is not bit-addressable; its bit hit is discarded
   csr_bit_merge #(.BASE(`CSR_ADDR_STACK)) u_sp (
      .i_cur(sp_r), .i_addr(I_SFR_ADDR), .i_byte_wr(I_SFR_WR), .i_byte_data(I_SFR_WDATA),
      .i_bit_wr(1'b0), .i_bit_addr(I_BIT_ADDR), .i_bit_val(I_BIT_WVAL),
      .o_next(sp_sw), .o_hit(sp_hit), .o_bit_hit());
   csr_bit_merge #(.BASE(`CSR_ADDR_PRIMARY)) u_acc (
      .i_cur(acc_r), .i_addr(I_SFR_ADDR), .i_byte_wr(I_SFR_WR), .i_byte_data(I_SFR_WDATA),
      .i_bit_wr(I_BIT_WR), .i_bit_addr(I_BIT_ADDR), .i_bit_val(I_BIT_WVAL),
      .o_next(acc_sw), .o_hit(acc_hit), .o_bit_hit(acc_bhit));
   csr_bit_merge #(.BASE(`CSR_ADDR_SECOND)) u_sec (
      .i_cur(sec_r), .i_addr(I_SFR_ADDR), .i_byte_wr(I_SFR_WR), .i_byte_data(I_SFR_WDATA),
      .i_bit_wr(I_BIT_WR), .i_bit_addr(I_BIT_ADDR), .i_bit_val(I_BIT_WVAL),
      .o_next(sec_sw), .o_hit(sec_hit), .o_bit_hit(sec_bhit));
   csr_bit_merge #(.BASE(`CSR_ADDR_FLAGS)) u_flg (
      .i_cur(flg_r), .i_addr(I_SFR_ADDR), .i_byte_wr(I_SFR_WR), .i_byte_data(I_SFR_WDATA),
      .i_bit_wr(I_BIT_WR), .i_bit_addr(I_BIT_ADDR), .i_bit_val(I_BIT_WVAL),
      .o_next(flg_sw), .o_hit(flg_hit), .o_bit_hit(flg_bhit));

   wire acc_sw_wr = acc_hit | acc_bhit;
   wire sec_sw_wr = sec_hit | sec_bhit;
   wire flg_sw_wr = flg_hit | flg_bhit;

   // ==================================================
   // Arithmetic flag computation
   reg  [8:0]  sum9;
   reg  [4:0]  nib5;
   reg  [15:0] prod;
   reg         cy_new;
   reg         ac_new;
   reg         ov_new;
   reg  [7:0]  sp_nxt;
   reg  [7:0]  acc_nxt;
   reg  [7:0]  sec_nxt;
   reg  [7:0]  flg_nxt;
   // Add and subtract report signed two's-complement overflow in the excess flag

   always @* begin
      sum9   = 9'h000;
      nib5   = 5'h00;
      prod   = {8'h00, acc_r} * {8'h00, sec_r};
      cy_new = flg_r[`CSR_FLD_CARRY];
      ac_new = flg_r[`CSR_FLD_HALF];
      ov_new = flg_r[`CSR_FLD_EXCESS];
      if (I_ADD_OP) begin
         sum9   = {1'b0, acc_r} + {1'b0, I_OPND} + {8'h00, I_CARRY_IN};
         nib5   = {1'b0, acc_r[3:0]} + {1'b0, I_OPND[3:0]} + {4'h0, I_CARRY_IN};
         cy_new = sum9[8];
         ac_new = nib5[4];
         ov_new = (acc_r[7] == I_OPND[7]) && (sum9[7] != acc_r[7]);
      end else if (I_SUB_OP) begin
         sum9   = {1'b0, acc_r} - {1'b0, I_OPND} - {8'h00, I_CARRY_IN};
         nib5   = {1'b0, acc_r[3:0]} - {1'b0, I_OPND[3:0]} - {4'h0, I_CARRY_IN};
         cy_new = sum9[8];
         ac_new = nib5[4];
         ov_new = (acc_r[7] != I_OPND[7]) && (sum9[7] != acc_r[7]);
      end else if (I_MUL_OP) begin
         cy_new = 1'b0;
         ov_new = prod > `CSR_MUL_LIMIT;
      end else if (I_DIV_OP) begin
         cy_new = 1'b0;
         ov_new = (sec_r == 8'h00);
      end else if (I_CARRY_LD) begin
         cy_new = I_CARRY_VAL;
      end

      // Stack pointer: software write wins, push pre-increments
      sp_nxt = sp_r;
      if (sp_hit) begin
         sp_nxt = sp_sw;
      end else if (I_PUSH) begin
         sp_nxt = sp_r + `CSR_ONE8;
      end else if (I_POP) begin
         sp_nxt = sp_r - `CSR_ONE8;
      end

      acc_nxt = acc_sw_wr ? acc_sw : (I_PRIMARY_LD ? I_PRIMARY_VAL : acc_r);
      sec_nxt = sec_sw_wr ? sec_sw : (I_SECOND_LD ? I_SECOND_VAL : sec_r);

      // User flag zero only moves through software paths
      flg_nxt = flg_r;
      flg_nxt[`CSR_FLD_CARRY]  = cy_new;
      flg_nxt[`CSR_FLD_HALF]   = ac_new;
      flg_nxt[`CSR_FLD_EXCESS] = ov_new;
      if (flg_sw_wr) begin
         flg_nxt = flg_sw;
      end
      flg_nxt[`CSR_FLD_PARITY] = ^acc_nxt;
   end

   // ==================================================
   // State and outputs
   always @(posedge I_CLOCK) begin
      if (I_SYS_RST) begin
         sp_r  <= `CSR_RST_STACK;
         acc_r <= `CSR_RST_PRIMARY;
         sec_r <= `CSR_RST_SECOND;
         flg_r <= `CSR_RST_FLAGS;
         O_SFR_RDATA           <= 8'h00;
         O_SFR_HIT             <= 1'b0;
         O_STACK_TOP_POINTER   <= `CSR_RST_STACK;
         O_PUSH_ADDR           <= `CSR_RST_STACK + `CSR_ONE8;
         O_PRIMARY_WORKING_REG <= `CSR_RST_PRIMARY;
         O_SECOND_OPERAND_REG  <= `CSR_RST_SECOND;
         O_CPU_FLAGS_WORD      <= `CSR_RST_FLAGS;
         O_BANK_BASE           <= 8'h00;
      end else begin
         sp_r  <= sp_nxt;
         acc_r <= acc_nxt;
         sec_r <= sec_nxt;
         flg_r <= flg_nxt;
         O_STACK_TOP_POINTER   <= sp_nxt;
         O_PUSH_ADDR           <= sp_nxt + `CSR_ONE8;
         O_PRIMARY_WORKING_REG <= acc_nxt;
         O_SECOND_OPERAND_REG  <= sec_nxt;
         O_CPU_FLAGS_WORD      <= flg_nxt;
         O_BANK_BASE <= {3'h0, flg_nxt[`CSR_FLD_BANK_HI:`CSR_FLD_BANK_LO],
                         3'h0};
         O_SFR_HIT   <= 1'b0;
         O_SFR_RDATA <= 8'h00;
         if (I_SFR_RD) begin
            case (I_SFR_ADDR)
               `CSR_ADDR_STACK: begin
                  O_SFR_RDATA <= sp_r;
                  O_SFR_HIT   <= 1'b1;
               end
               `CSR_ADDR_FLAGS: begin
                  O_SFR_RDATA <= flg_r;
                  O_SFR_HIT   <= 1'b1;
               end
               `CSR_ADDR_PRIMARY: begin
                  O_SFR_RDATA <= acc_r;
                  O_SFR_HIT   <= 1'b1;
               end
               `CSR_ADDR_SECOND: begin
                  O_SFR_RDATA <= sec_r;
                  O_SFR_HIT   <= 1'b1;
               end
               default: begin
                  O_SFR_RDATA <= 8'h00;
               end
            endcase
         end
      end
   end

endmodule // csr_core_special_regs

//--- core/csr_core_regs.vh
// Purpose : Addresses, field positions and reset values of the core special registers
// Assumes : 8-bit special-function address space, bit address is register base plus index
// Notes   : Definitions only
`ifndef CSR_CORE_REGS_VH
`define CSR_CORE_REGS_VH

// ==================================================
// Register byte addresses
`define CSR_ADDR_STACK      8'h81
`define CSR_ADDR_FLAGS      8'hd0
`define CSR_ADDR_PRIMARY    8'he0
`define CSR_ADDR_SECOND     8'hf0

// ==================================================
// Reset values
`define CSR_RST_STACK       8'h07
`define CSR_RST_FLAGS       8'h00
`define CSR_RST_PRIMARY     8'h00
`define CSR_RST_SECOND      8'h00

// ==================================================
// Flag word field positions
`define CSR_FLD_CARRY       7
`define CSR_FLD_HALF        6
`define CSR_FLD_USER0       5
`define CSR_FLD_BANK_HI     4
`define CSR_FLD_BANK_LO     3
`define CSR_FLD_EXCESS      2
`define CSR_FLD_USER1       1
`define CSR_FLD_PARITY      0

// ==================================================
// Bit address decode: bit address = register base | bit index
`define CSR_BIT_IDX_W       3
`define CSR_BIT_BASE_MSB    7
`define CSR_BIT_BASE_LSB    3
`define CSR_BANK_BASE_LSB   3
`define CSR_ONE8            8'h01
`define CSR_MUL_LIMIT       16'h00ff

`endif

//--- core/csr_bit_merge.v
// Purpose : Applies one byte write or one single-bit write to an 8-bit register image
// Assumes : Byte and bit writes for one register never arrive in the same cycle
// Notes   : Pure combinational; the owner register holds the flop
`include "csr_core_regs.vh"

module csr_bit_merge #(
   parameter [7:0] BASE = 8'h00
) (
   input  wire [7:0] i_cur,
   input  wire [7:0] i_addr,
   input  wire       i_byte_wr,
   input  wire [7:0] i_byte_data,
   input  wire       i_bit_wr,
   input  wire [7:0] i_bit_addr,
   input  wire       i_bit_val,
   output reg  [7:0] o_next,
   output reg        o_hit,
   output reg        o_bit_hit
);

   always @* begin
      o_hit     = i_byte_wr && (i_addr == BASE);
      o_bit_hit = i_bit_wr && (i_bit_addr[`CSR_BIT_BASE_MSB:`CSR_BIT_BASE_LSB]
                  == BASE[`CSR_BIT_BASE_MSB:`CSR_BIT_BASE_LSB]);
      o_next    = i_cur;
      if (o_hit) begin
         o_next = i_byte_data;
      end else if (o_bit_hit) begin
         o_next[i_bit_addr[`CSR_BIT_IDX_W-1:0]] = i_bit_val;
      end
   end

endmodule // csr_bit_merge

//--- test/csr_chk_checker.sv
// Purpose: Port-level assertions on the core special registers
// Assumes: One clock, synchronous active-high reset
// Notes: Software writes to the flag word win, so datapath checks skip them
module csr_chk (
   input logic       I_CLOCK,
   input logic       I_SYS_RST,
   input logic       I_SFR_WR,
   input logic       I_SFR_RD,
   input logic       I_BIT_WR,
   input logic       I_PUSH,
   input logic       I_ADD_OP,
   input logic       I_SUB_OP,
   input logic       I_MUL_OP,
   input logic       I_DIV_OP,
   input logic       I_CARRY_IN,
   input logic       O_SFR_HIT,
   input logic [7:0] I_SFR_ADDR,
   input logic [7:0] I_SFR_WDATA,
   input logic [7:0] I_BIT_ADDR,
   input logic [7:0] I_OPND,
   input logic [7:0] O_SFR_RDATA,
   input logic [7:0] O_STACK_TOP_POINTER,
   input logic [7:0] O_PRIMARY_WORKING_REG,
   input logic [7:0] O_SECOND_OPERAND_REG,
   input logic [7:0] O_CPU_FLAGS_WORD,
   input logic [7:0] O_BANK_BASE
);
   timeunit 1ns;
   timeprecision 1ns;
   logic       fw, mov, dz;
   logic [1:0] ch;
   logic [8:0] sum;
   logic [4:0] nib;
   assign fw  = (I_SFR_WR && I_SFR_ADDR == 8'hd0) || (I_BIT_WR && I_BIT_ADDR[7:3] == 5'h1a);
   assign sum = O_PRIMARY_WORKING_REG + I_OPND + I_CARRY_IN;
   assign nib = O_PRIMARY_WORKING_REG[3:0] + I_OPND[3:0] + I_CARRY_IN;
   assign ch  = {sum[8], nib[4]};
   assign mov = (O_PRIMARY_WORKING_REG * O_SECOND_OPERAND_REG) > 16'h00ff;
   assign dz  = O_SECOND_OPERAND_REG == 8'h00;
   // ====
   // Assertions
   default clocking @(posedge I_CLOCK); endclocking
   default disable iff (I_SYS_RST);
   property p_push;
      I_PUSH && !I_SFR_WR |=> O_STACK_TOP_POINTER == $past(O_STACK_TOP_POINTER) + 8'h01;
   endproperty
   a_push: assert property (p_push) else $error("stack push step wrong");
   property p_rst;
      $fell(I_SYS_RST) |-> O_STACK_TOP_POINTER == 8'h07 && O_CPU_FLAGS_WORD == 8'h00;
   endproperty
   a_rst: assert property (p_rst) else $error("reset value wrong");
   property p_stkwr;
      I_SFR_WR && I_SFR_ADDR == 8'h81 |=> O_STACK_TOP_POINTER == $past(I_SFR_WDATA);
   endproperty
   a_stkwr: assert property (p_stkwr) else $error("stack write lost");
   property p_rd;
      I_SFR_RD && I_SFR_ADDR == 8'he0
         |=> O_SFR_HIT && O_SFR_RDATA == $past(O_PRIMARY_WORKING_REG);
   endproperty
   a_rd: assert property (p_rd) else $error("primary read wrong");
   property p_add; I_ADD_OP && !fw |=> O_CPU_FLAGS_WORD[7:6] == $past(ch); endproperty
   a_add: assert property (p_add) else $error("add carry flags wrong");
   property p_mul;
      I_MUL_OP && !I_ADD_OP && !I_SUB_OP && !fw |=> O_CPU_FLAGS_WORD[2] == $past(mov);
   endproperty
   a_mul: assert property (p_mul) else $error("multiply excess wrong");
   property p_div;
      I_DIV_OP && !(I_ADD_OP || I_SUB_OP || I_MUL_OP) && !fw
         |=> O_CPU_FLAGS_WORD[2] == $past(dz);
   endproperty
   a_div: assert property (p_div) else $error("divide excess wrong");
   property p_bank; O_BANK_BASE == {3'h0, O_CPU_FLAGS_WORD[4:3], 3'h0}; endproperty
   a_bank: assert property (p_bank) else $error("bank base wrong");
   property p_user; !fw |=> $stable(O_CPU_FLAGS_WORD[5]); endproperty
   a_user: assert property (p_user) else $error("user flag moved");
   property p_par; O_CPU_FLAGS_WORD[0] == ^O_PRIMARY_WORKING_REG; endproperty
   a_par: assert property (p_par) else $error("parity wrong");
endmodule // csr_chk

bind csr_core_special_regs csr_chk chk_u (.I_CLOCK, .I_SYS_RST, .I_SFR_WR, .I_SFR_RD, .I_BIT_WR,
   .I_PUSH, .I_ADD_OP, .I_SUB_OP, .I_MUL_OP, .I_DIV_OP, .I_CARRY_IN, .O_SFR_HIT, .I_SFR_ADDR,
   .I_SFR_WDATA, .I_BIT_ADDR, .I_OPND, .O_SFR_RDATA, .O_STACK_TOP_POINTER, .O_PRIMARY_WORKING_REG,
   .O_SECOND_OPERAND_REG, .O_CPU_FLAGS_WORD, .O_BANK_BASE);

//--- test/csr_dp_model.sv
// Purpose: Datapath model issuing one-cycle operation strobes
// Assumes: Strobes move on the falling edge only
// Notes: Strobe bits add sub mul div cld push pop pld sld
module csr_dp_model (
   input  logic       i_clk,
   output logic [8:0] o_strb,
   output logic [7:0] o_val,
   output logic       o_bit
);
   timeunit 1ns;
   timeprecision 1ns;
   initial begin
      o_strb = 9'h000;
      o_val = 8'h00;
      o_bit = 1'b0;
   end
   task automatic op(input int k, input logic [7:0] v, input logic c);
      @(negedge i_clk);
      o_strb = 9'h001 << k;
      o_val = v;
      o_bit = c;
      @(negedge i_clk);
      o_strb = 9'h000;
      // Released operands flip so stale values never pass for held ones
      o_val = ~v;
      o_bit = ~c;
   endtask
endmodule // csr_dp_model

//--- test/tb.sv
// Purpose: Self-checking bench for the core special registers
// Assumes: 25 MHz clock, inputs driven on the falling edge
// Notes: Reads are queued and matched when the hit pulse shows
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic       clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, bw = 1'b0, bv = 1'b0, hit, cb, c;
   logic [7:0] ad = 8'h00, wd = 8'h00, ba = 8'h00, val, rdat, stko, pa, prio, seco, fo, bb;
   logic [7:0] stk, pri, sec, flg, opd;
   logic [8:0] st, s;
   logic [7:0] q[$];
   logic [7:0] ta[3] = '{8'hff, 8'h10, 8'h55};
   logic [7:0] tsec[3] = '{8'h01, 8'h10, 8'h00};
   int         errors = 0;
   int         checks = 0;
   csr_dp_model dp_u (.i_clk(clk), .o_strb(st), .o_val(val), .o_bit(cb));
   csr_core_special_regs dut_u (.I_CLOCK(clk), .I_SYS_RST(rst), .I_SFR_ADDR(ad), .I_SFR_WR(wr),
      .I_SFR_WDATA(wd), .I_SFR_RD(rd), .I_BIT_ADDR(ba), .I_BIT_WR(bw), .I_BIT_WVAL(bv),
      .I_PUSH(st[5]), .I_POP(st[6]), .I_PRIMARY_LD(st[7]), .I_PRIMARY_VAL(val),
      .I_SECOND_LD(st[8]), .I_SECOND_VAL(val), .I_ADD_OP(st[0]), .I_SUB_OP(st[1]),
      .I_CARRY_IN(cb), .I_OPND(val), .I_MUL_OP(st[2]), .I_DIV_OP(st[3]), .I_CARRY_LD(st[4]),
      .I_CARRY_VAL(cb), .O_SFR_RDATA(rdat), .O_SFR_HIT(hit), .O_STACK_TOP_POINTER(stko),
      .O_PUSH_ADDR(pa), .O_PRIMARY_WORKING_REG(prio), .O_SECOND_OPERAND_REG(seco),
      .O_CPU_FLAGS_WORD(fo), .O_BANK_BASE(bb));
   initial begin
      forever #20 clk = ~clk;
   end
   // ====
   // Bus tasks and checks
   task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
      checks++;
      if (g !== e) begin
         errors++;
         $display("BAD %s exp %h got %h", n, e, g);
      end
   endtask
   task automatic wr_b(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      ad = a;
      wd = d;
      wr = 1'b1;
      @(negedge clk);
      wr = 1'b0;
   endtask
   task automatic bit_w(input logic [7:0] a, input logic v);
      @(negedge clk);
      ba = a;
      bv = v;
      bw = 1'b1;
      @(negedge clk);
      bw = 1'b0;
   endtask
   task automatic rd_b(input logic [7:0] a, input logic [7:0] e, input logic m);
      @(negedge clk);
      ad = a;
      rd = 1'b1;
      if (m) q.push_back(e);
      @(negedge clk);
      rd = 1'b0;
   endtask
   function automatic logic [7:0] fx();
      return {flg[7:1], ^pri};
   endfunction
   task automatic give_verdict;
      if (errors == 0 && checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   // Every hit pulse must match the oldest queued read
   always @(negedge clk) begin
      if (hit === 1'b1) begin
         if (q.size() == 0) chk("spare hit", 8'h00, 8'h01);
         else chk("read", q.pop_front(), rdat);
      end
   end
   initial begin
      #200000;
      errors++;
      give_verdict();
   end
   // ====
   // Main sequence
   initial begin
      void'($urandom(32'h5bbb));
      repeat (12) @(posedge clk);
      @(negedge clk) rst = 1'b0;
      rd_b(8'h81, 8'h07, 1'b1);
      rd_b(8'he0, 8'h00, 1'b1);
      rd_b(8'hf0, 8'h00, 1'b1);
      rd_b(8'hd0, 8'h00, 1'b1);
      rd_b(8'h82, 8'h00, 1'b0);
      chk("unmapped", 8'h00, rdat | {7'h00, hit});
      wr_b(8'h81, 8'hfe);
      dp_u.op(5, 8'h00, 1'b0);
      dp_u.op(5, 8'h00, 1'b0);
      chk("push addr", 8'h01, pa);
      dp_u.op(6, 8'h00, 1'b0);
      rd_b(8'h81, 8'hff, 1'b1);
      wr_b(8'hd0, 8'h19);
      chk("bank base", 8'h18, bb);
      bit_w(8'hd5, 1'b1);
      flg = 8'h38;
      for (int i = 0; i < 12; i++) begin
         pri = i < 3 ? ta[i] : 8'($urandom);
         sec = i < 3 ? tsec[i] : 8'($urandom);
         opd = 8'($urandom);
         c = 1'($urandom);
         if (i % 2) dp_u.op(7, pri, 1'b0);
         else wr_b(8'he0, pri);
         dp_u.op(8, sec, 1'b0);
         dp_u.op(0, opd, c);
         s = {1'b0, pri} + opd + c;
         flg[7] = s[8];
         flg[6] = ({1'b0, pri[3:0]} + opd[3:0] + c) > 5'h0f;
         flg[2] = (pri[7] == opd[7]) && (s[7] != pri[7]);
         rd_b(8'hd0, fx(), 1'b1);
         dp_u.op(1, opd, c);
         s = {1'b0, pri} - opd - c;
         flg[7] = s[8];
         flg[6] = pri[3:0] < {1'b0, opd[3:0]} + c;
         flg[2] = (pri[7] != opd[7]) && (s[7] != pri[7]);
         rd_b(8'hd0, fx(), 1'b1);
         dp_u.op(2, 8'h00, 1'b0);
         chk("mul excess", {7'h0, pri * sec > 16'h00ff}, {7'h0, fo[2]});
         dp_u.op(3, 8'h00, 1'b0);
         chk("div excess", {7'h0, sec == 8'h00}, {7'h0, fo[2]});
         dp_u.op(4, 8'h00, c);
         chk("carry load", {7'h0, c}, {7'h0, fo[7]});
      end
      wr_b(8'hd0, 8'hff);
      flg = 8'hfe;
      for (int k = 0; k < 8; k++) begin
         bv = 1'($urandom);
         pri[k] = ~pri[k];
         sec[k] = ~sec[k];
         bit_w(8'he0 | k[7:0], pri[k]);
         bit_w(8'hf0 | k[7:0], sec[k]);
         chk("primary bit", pri, prio);
         chk("second bit", sec, seco);
      end
      bit_w(8'hd0, ~fo[0]);
      rd_b(8'hd0, fx(), 1'b1);
      rst = 1'b1;
      repeat (2) @(negedge clk);
      rst = 1'b0;
      chk("stack again", 8'h07, stko);
      chk("flags again", 8'h00, fo);
      repeat (2) @(negedge clk);
      chk("queue left", 8'h00, 8'(q.size()));
      give_verdict();
   end
endmodule // tb
